// ---- stil_tap.sv ----
// Instruction decode and data register selection of the scan port of a
// synchronous memory. The test clock, mode select, data in and the pin
// ring are sampled by the fast reference clock.
// Assumes the test clock runs at least four times slower than ref_clk_in
// and that the memory core honours mem_out_disable_out.
//
// Timing: an edge of the test clock at the pin reaches the second
// synchroniser stage two reference clocks later and is acted on at the
// third, so each test-clock phase must last two reference periods or
// an edge can be lost altogether.
// Serial out and its enable are registers that move only after a
// detected fall. The output disable follows the instruction register
// one reference clock later; that register loads on entry to
// Update-IR, and is forced back to the identity code in reset state.
//
// Snapshot port: every boundary-register capture also leaves a copy of the pin ring for
// a reader on the reference clock. Two copies wait in the buffer and a
// third in a pending slot; a further capture while all three wait
// replaces the pending copy, so a reader that stalls that long loses
// one word for each such capture.
//
// Limitation: the ring is resynchronised bit by bit, so a pin that
// moves near a capture may show either value, and the bits of one
// capture need not come from the same reference cycle.
//
// Functional notes
// - Code 001 loads the fixed 32-bit identity word and shifts it out.
// - Identity instruction becomes current at power-up and in reset state.
// - Code 010 captures pins, shifts boundary register, tri-states outputs.
// - Code 000 captures pins, shifts boundary register, tri-states outputs.
// - Code 100 snapshots all pins into boundary register at Capture-DR.
// - Captured boundary register shifts out once Shift-DR is entered.
// - Shifted-in boundary contents never drive pins or memory inputs.
// - Update-DR under sample acts exactly like a pause.
// - Code 111 puts the one-bit bypass register in Shift-DR path.
// - Identity, sample and bypass leave memory outputs untouched.
// - Capture-IR loads binary 01 into the low instruction bits.
// - Five test-clock rises with mode high reset the controller.
// - Inputs sampled on test-clock rise; serial out changes on fall.
// - Identity word bit zero is always one.
`timescale 1ns/1ps
`include "stil_map.svh"

module stil_tap #(
  // Upper identity bits; the value is arbitrary.
  parameter logic [`STIL_ID_W-2:0] ID_UPPER = 31'h00000000
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic [`STIL_BSR_W-1:0] pin_ring_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic mem_out_disable_out,
  output logic [`STIL_BSR_W-1:0] snap_data_out,
  output logic snap_valid_out,
  input wire logic snap_ready_in
);

  // State, its next value and the decoded clock edges.
  stil_pkg::stil_state_t st_reg;
  stil_pkg::stil_state_t st_next;
  logic tck_rise;
  logic tck_fall;
  logic buf_ready;
  stil_pkg::stil_tap_state_t tap_step;

  // Next controller state for one test-clock rise. Every state is
  // listed, so the walk can never leave the sixteen legal states.
  function automatic stil_pkg::stil_tap_state_t tap_next(
    input stil_pkg::stil_tap_state_t s,
    input logic m
  );
    stil_pkg::stil_tap_state_t n;
    n = s;
    unique case (s)
      stil_pkg::ST_RESET: n = m ? stil_pkg::ST_RESET : stil_pkg::ST_IDLE;
      stil_pkg::ST_IDLE: n = m ? stil_pkg::ST_SEL_DR : stil_pkg::ST_IDLE;
      // Data column.
      stil_pkg::ST_SEL_DR: n = m ? stil_pkg::ST_SEL_IR : stil_pkg::ST_CAP_DR;
      stil_pkg::ST_CAP_DR: n = m ? stil_pkg::ST_EX1_DR : stil_pkg::ST_SH_DR;
      stil_pkg::ST_SH_DR: n = m ? stil_pkg::ST_EX1_DR : stil_pkg::ST_SH_DR;
      stil_pkg::ST_EX1_DR: n = m ? stil_pkg::ST_UPD_DR : stil_pkg::ST_PAU_DR;
      stil_pkg::ST_PAU_DR: n = m ? stil_pkg::ST_EX2_DR : stil_pkg::ST_PAU_DR;
      stil_pkg::ST_EX2_DR: n = m ? stil_pkg::ST_UPD_DR : stil_pkg::ST_SH_DR;
      stil_pkg::ST_UPD_DR: n = m ? stil_pkg::ST_SEL_DR : stil_pkg::ST_IDLE;
      // Instruction column.
      stil_pkg::ST_SEL_IR: n = m ? stil_pkg::ST_RESET : stil_pkg::ST_CAP_IR;
      stil_pkg::ST_CAP_IR: n = m ? stil_pkg::ST_EX1_IR : stil_pkg::ST_SH_IR;
      stil_pkg::ST_SH_IR: n = m ? stil_pkg::ST_EX1_IR : stil_pkg::ST_SH_IR;
      stil_pkg::ST_EX1_IR: n = m ? stil_pkg::ST_UPD_IR : stil_pkg::ST_PAU_IR;
      stil_pkg::ST_PAU_IR: n = m ? stil_pkg::ST_EX2_IR : stil_pkg::ST_PAU_IR;
      stil_pkg::ST_EX2_IR: n = m ? stil_pkg::ST_UPD_IR : stil_pkg::ST_SH_IR;
      stil_pkg::ST_UPD_IR: n = m ? stil_pkg::ST_SEL_DR : stil_pkg::ST_IDLE;
    endcase
    return n;
  endfunction : tap_next

  // Data register chosen by an instruction code; capture, shift and
  // serial out all decode through here so they can never disagree.
  function automatic stil_pkg::stil_dr_sel_t dr_sel(
    input logic [`STIL_IR_W-1:0] op
  );
    stil_pkg::stil_dr_sel_t r;
    unique case (op)
      `STIL_OP_IDCODE: r = stil_pkg::SEL_ID;
      `STIL_OP_EXTEST,
      `STIL_OP_SAMPLEZ,
      `STIL_OP_SAMPLE: r = stil_pkg::SEL_BSR;
      // Reserved codes fall back to the one-bit path: a stray load then
      // costs one bit of delay and never disturbs the memory.
      default: r = stil_pkg::SEL_BYP;
    endcase
    return r;
  endfunction : dr_sel

  // The two codes that take the memory outputs off the bus. Every other
  // code leaves the drivers to the memory's own control.
  function automatic logic out_off(input logic [`STIL_IR_W-1:0] op);
    return (op == `STIL_OP_EXTEST) || (op == `STIL_OP_SAMPLEZ);
  endfunction : out_off

  // Edges are found on the second synchroniser stage and its follower.
  // A rise and a fall can never be seen in the same cycle.
  assign tck_rise = st_reg.tck_sy[1] & ~st_reg.tck_prev;
  assign tck_fall = ~st_reg.tck_sy[1] & st_reg.tck_prev;

  // Controller state after the next detected rise; the instruction load
  // and the state register both read it.
  assign tap_step = tap_next(st_reg.tap, st_reg.tms_sy[1]);

  // Next-state logic of the whole port. Order matters below: the
  // hand-off clear comes before a capture so a new snapshot wins, and
  // the reset-state override comes after the instruction load.
  always_comb begin
    st_next = st_reg;
    // Pin samplers; only the second stage of each pair is read below,
    // which keeps a metastable first stage away from the logic.
    st_next.tck_sy = {st_reg.tck_sy[0], tck_in};
    st_next.tms_sy = {st_reg.tms_sy[0], tms_in};
    st_next.tdi_sy = {st_reg.tdi_sy[0], tdi_in};
    // The wide pin ring takes the same two stages as the test pins.
    st_next.ring_sy1 = pin_ring_in;
    st_next.ring_sy2 = st_reg.ring_sy1;
    st_next.tck_prev = st_reg.tck_sy[1];

    // A snapshot waiting for the buffer leaves once it is accepted.
    // The buffer takes the pending slot as soon as it has room.
    if (st_reg.pend_v && buf_ready) begin
      st_next.pend_v = 1'b0;
    end

    // sample on rise
    // Everything the test pins ask for happens in this one cycle.
    if (tck_rise) begin
      unique case (st_reg.tap)
        // capture pattern
        // Top bit zero; the low pair gives the board a fixed 01 to check.
        stil_pkg::ST_CAP_IR: begin
          st_next.ir_sh = {`STIL_IR_CAPT_TOP, `STIL_IR_CAPT};
        end
        // Instruction bits enter at the top, as on every path.
        stil_pkg::ST_SH_IR: begin
          st_next.ir_sh = {st_reg.tdi_sy[1], st_reg.ir_sh[`STIL_IR_W-1:1]};
        end
        stil_pkg::ST_CAP_DR: begin
          unique case (dr_sel(st_reg.ir))
            stil_pkg::SEL_ID: begin
              st_next.id_sh = {ID_UPPER, `STIL_ID_PRESENT};
            end
            // pin snapshot
            // Captured for 000, 010 and 100 alike; only the disable differs.
            // Set wins over the hand-off clear in this same cycle.
            stil_pkg::SEL_BSR: begin
              st_next.bsr = st_reg.ring_sy2;
              st_next.pend_v = 1'b1;
              st_next.pend_d = st_reg.ring_sy2;
            end
            // Bypass captures zero, a known bit for the board to check.
            stil_pkg::SEL_BYP: begin
              st_next.byp = 1'b0;
            end
          endcase
        end
        // shift selected path
        // Each path takes data in at its top and drops its bottom bit.
        stil_pkg::ST_SH_DR: begin
          unique case (dr_sel(st_reg.ir))
            stil_pkg::SEL_ID: begin
              st_next.id_sh = {st_reg.tdi_sy[1],
                               st_reg.id_sh[`STIL_ID_W-1:1]};
            end
            stil_pkg::SEL_BSR: begin
              st_next.bsr = {st_reg.tdi_sy[1],
                             st_reg.bsr[`STIL_BSR_W-1:1]};
            end
            stil_pkg::SEL_BYP: begin
              st_next.byp = st_reg.tdi_sy[1];
            end
          endcase
        end
        // no update action
        // Shifted contents are never copied to any pin or core input.
        stil_pkg::ST_UPD_DR: begin
          st_next.bsr = st_reg.bsr;
        end
        // Other states leave every shift path as it is.
        default: begin
          st_next.ir_sh = st_reg.ir_sh;
        end
      endcase
      // act at Update-IR
      // The code is taken on entry to Update-IR, when the controller has
      // committed to it, so leaving the state changes nothing.
      if (tap_step == stil_pkg::ST_UPD_IR) begin
        st_next.ir = st_reg.ir_sh;
      end
      st_next.tap = tap_step;
    end

    // identity on reset state
    // Checked every cycle, not only on a rise, so power-up and a
    // mode-high reset both land on the identity code.
    if (st_reg.tap == stil_pkg::ST_RESET) begin
      st_next.ir = `STIL_OP_IDCODE;
    end

    // output on fall
    // Serial out drives only while a shift state is current.
    // Elsewhere the pin is let go at the first fall and the board
    // pull-up holds it; the last bit shown stays in the register.
    if (tck_fall) begin
      if (st_reg.tap == stil_pkg::ST_SH_IR) begin
        st_next.tdo = st_reg.ir_sh[0];
        st_next.tdo_oe_n = 1'b0;
      end else if (st_reg.tap == stil_pkg::ST_SH_DR) begin
        unique case (dr_sel(st_reg.ir))
          stil_pkg::SEL_ID: st_next.tdo = st_reg.id_sh[0];
          stil_pkg::SEL_BSR: st_next.tdo = st_reg.bsr[0];
          stil_pkg::SEL_BYP: st_next.tdo = st_reg.byp;
        endcase
        st_next.tdo_oe_n = 1'b0;
      end else begin
        st_next.tdo_oe_n = 1'b1;
      end
    end

    // core output disable
    // A register here keeps glitches of the decode off the core.
    st_next.mem_dis = out_off(st_reg.ir);
  end

  // All state in one register; reset is the power-up reset.
  // The pin samplers start at the idle level of their pins, so no
  // false edge or mode bit follows the release of reset.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.tap <= stil_pkg::ST_RESET;
      st_reg.ir <= `STIL_OP_IDCODE;
      st_reg.ir_sh <= `STIL_OP_IDCODE;
      st_reg.tms_sy <= `STIL_TMS_RST;
      st_reg.tdi_sy <= `STIL_TDI_RST;
      st_reg.tdo_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Captured snapshots go out through a two-entry buffer behind a pending
  // slot; a new capture while the pending copy still waits replaces it.
  stil_buf #(
    .WIDTH(`STIL_BSR_W)
  ) u_buf (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(st_reg.pend_d),
    .in_valid_in(st_reg.pend_v),
    .in_ready_out(buf_ready),
    .out_data_out(snap_data_out),
    .out_valid_out(snap_valid_out),
    .out_ready_in(snap_ready_in)
  );

  // Every output but the snapshot port comes straight from a register.
  assign tdo_out = st_reg.tdo;
  assign tdo_oe_n_out = st_reg.tdo_oe_n;
  assign mem_out_disable_out = st_reg.mem_dis;

endmodule : stil_tap

// ---- stil_map.svh ----
// Constants of the scan-port instruction logic: widths, codes, capture
// patterns and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef STIL_MAP_SVH
`define STIL_MAP_SVH

// Register lengths.
`define STIL_IR_W 3
`define STIL_ID_W 32
`define STIL_BSR_W 75

// Instruction codes.
`define STIL_OP_EXTEST 3'h0
`define STIL_OP_IDCODE 3'h1
`define STIL_OP_SAMPLEZ 3'h2
`define STIL_OP_SAMPLE 3'h4
`define STIL_OP_BYPASS 3'h7

// Pattern loaded into the low instruction bits on instruction capture.
`define STIL_IR_CAPT 2'h1
`define STIL_IR_CAPT_TOP 1'h0

// Presence bit of the identification word.
`define STIL_ID_PRESENT 1'h1

// Reset values of the pin samplers (test inputs are pulled up).
`define STIL_TMS_RST 2'h3
`define STIL_TDI_RST 2'h3

`endif

// ---- stil_pkg.sv ----
// Types of the scan-port instruction logic: controller states, data
// register selection and the module state record.
// Assumes the constants header is present in the same folder.
`include "stil_map.svh"

package stil_pkg;

  // The sixteen controller states.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } stil_tap_state_t;

  // Data register placed between serial in and serial out.
  typedef enum logic [1:0] {
    SEL_ID, SEL_BSR, SEL_BYP
  } stil_dr_sel_t;

  // Whole state of the instruction logic.
  typedef struct packed {
    stil_tap_state_t tap;
    logic [`STIL_IR_W-1:0] ir;
    logic [`STIL_IR_W-1:0] ir_sh;
    logic [`STIL_BSR_W-1:0] bsr;
    logic [`STIL_ID_W-1:0] id_sh;
    logic byp;
    logic [1:0] tck_sy;
    logic tck_prev;
    logic [1:0] tms_sy;
    logic [1:0] tdi_sy;
    logic [`STIL_BSR_W-1:0] ring_sy1;
    logic [`STIL_BSR_W-1:0] ring_sy2;
    logic tdo;
    logic tdo_oe_n;
    logic mem_dis;
    logic pend_v;
    logic [`STIL_BSR_W-1:0] pend_d;
  } stil_state_t;

endpackage : stil_pkg

// ---- stil_buf.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-low reset; the head
// entry is always slot zero so the data output comes from a flip-flop.
`timescale 1ns/1ps
`include "stil_map.svh"

module stil_buf #(
  parameter int WIDTH = `STIL_BSR_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  typedef struct packed {
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
    logic [1:0] cnt;
  } stil_buf_t;

  stil_buf_t st_reg;
  stil_buf_t st_next;
  logic push;
  logic pop;

  // Full and empty follow the fill count directly.
  assign in_ready_out = (st_reg.cnt != 2'h2);
  assign out_valid_out = (st_reg.cnt != 2'h0);
  assign out_data_out = st_reg.d0;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Entries move toward slot zero as the head is taken.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.cnt)
      2'h0: begin
        if (push) begin
          st_next.d0 = in_data_in;
          st_next.cnt = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          st_next.d0 = in_data_in;
        end else if (pop) begin
          st_next.cnt = 2'h0;
        end else if (push) begin
          st_next.d1 = in_data_in;
          st_next.cnt = 2'h2;
        end
      end
      2'h2: begin
        if (pop) begin
          st_next.d0 = st_reg.d1;
          st_next.cnt = 2'h1;
        end
      end
      default: begin
        st_next.cnt = 2'h0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : stil_buf

// ---- stil_tap_properties.sv ----
// Port checker of the scan-port instruction logic.
// Assumes it is bound to stil_tap and shares its clock and reset.
`timescale 1ns/1ps
`include "stil_map.svh"
module stil_tap_properties (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic mem_out_disable_out,
  input wire logic [`STIL_BSR_W-1:0] snap_data_out,
  input wire logic snap_valid_out,
  input wire logic snap_ready_in
);
  logic tck_reg;
  logic [2:0] hi_reg;
  logic [2:0] hi_next;
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Count test-clock rises with mode high, saturating at five.
  always_comb begin
    hi_next = hi_reg;
    if (tck_in && !tck_reg) begin
      hi_next = tms_in ? ((hi_reg == 3'h5) ? hi_reg : hi_reg + 3'h1) : 3'h0;
    end
  end
  // Helper registers follow the pin; reset clears the run count.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_reg <= 1'b0;
      hi_reg <= 3'h0;
    end else begin
      tck_reg <= tck_in;
      hi_reg <= hi_next;
    end
  end
  // A recent test-clock fall, a recent rise, a completed mode reset.
  sequence s_after_fall;
    !$past(tck_in, 2) && !$past(tck_in, 3);
  endsequence
  sequence s_after_rise;
    $past(tck_in, 2);
  endsequence
  sequence s_mode_reset;
    hi_reg == 3'h5;
  endsequence
  property p_tdo_on_fall;
    $changed(tdo_out) |-> s_after_fall;
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("serial out moved away from a test-clock fall");
  property p_oe_on_fall;
    $changed(tdo_oe_n_out) |-> s_after_fall;
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("serial enable moved away from a test-clock fall");
  property p_dis_on_rise;
    $changed(mem_out_disable_out) |-> s_after_rise;
  endproperty
  a_dis_on_rise: assert property (p_dis_on_rise)
    else $error("output disable moved away from a test-clock rise");
  property p_dis_at_update;
    $rose(mem_out_disable_out) |-> tms_in;
  endproperty
  a_dis_at_update: assert property (p_dis_at_update)
    else $error("output disable rose outside an update step");
  property p_mode_reset;
    s_mode_reset |-> ##[0:6] !mem_out_disable_out;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("five mode-high rises left outputs disabled");
  property p_rst_quiet;
    $rose(rst_n_in) |-> (tdo_oe_n_out && !mem_out_disable_out) [*8];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("port not quiet after reset");
  property p_snap_hold;
    snap_valid_out && !snap_ready_in |=>
      snap_valid_out && $stable(snap_data_out);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("snapshot dropped while stalled");
  property p_valid_fall;
    $fell(snap_valid_out) |-> $past(snap_ready_in);
  endproperty
  a_valid_fall: assert property (p_valid_fall)
    else $error("snapshot valid fell without a take");
endmodule : stil_tap_properties
bind stil_tap stil_tap_properties u_props (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .tck_in(tck_in), .tms_in(tms_in),
  .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out),
  .mem_out_disable_out(mem_out_disable_out),
  .snap_data_out(snap_data_out), .snap_valid_out(snap_valid_out),
  .snap_ready_in(snap_ready_in));

// ---- stil_ctl_model.sv ----
// Behavioural board-level scan controller.
// Assumes its tasks are entered at a falling edge of ref_clk_in.
`timescale 1ns/1ps
module stil_ctl_model (
  input wire logic ref_clk_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  logic [74:0] dr_seen;
  logic [2:0] ir_seen;
  // Clock rests low between frames; data in idles high like its pull-up.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // read before rise
  // One 400 ns period; serial out is read just before the rise.
  task automatic step(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    repeat (2) @(negedge ref_clk_in);
    q = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    tck_out = 1'b0;
    repeat (2) @(negedge ref_clk_in);
  endtask : step
  // Plain state moves with data in released high.
  task automatic walk(input logic [7:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(m[i], 1'b1, q);
    end
  endtask : walk
  task automatic ir_scan(input logic [2:0] code);
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], ir_seen[i]);
    end
    walk(8'h01, 2);
  endtask : ir_scan
  task automatic dr_scan(input int n, input logic [74:0] din);
    dr_seen = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dr_seen[i]);
    end
    walk(8'h01, 2);
  endtask : dr_scan
  task automatic go_reset();
    walk(8'h1f, 5);
    walk(8'h00, 1);
  endtask : go_reset
endmodule : stil_ctl_model

// ---- tb_stil_tap.sv ----
// Self-checking bench of the scan-port instruction logic.
// Assumes the controller model and the checker are compiled first.
`timescale 1ns/1ps
module tb_stil_tap;
  localparam logic [30:0] ID_HI = 31'h12345678; // Arbitrary value.
  localparam int LIMIT = 60000;
  logic clk, rst_n, tck, tms, tdi, tdo, oe_n, dis, valid, ready;
  logic [74:0] ring, snap;
  logic [74:0] pat [3];
  int n_fail, samples_checked, cycles;
  stil_tap #(.ID_UPPER(ID_HI)) u_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .pin_ring_in(ring),
    .tdo_out(tdo), .tdo_oe_n_out(oe_n), .mem_out_disable_out(dis),
    .snap_data_out(snap), .snap_valid_out(valid), .snap_ready_in(ready));
  stil_ctl_model u_ctl (.ref_clk_in(clk), .tck_out(tck), .tms_out(tms),
    .tdi_out(tdi), .tdo_in(tdo));
  // Reference clock of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // A hang is cut short and counted as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic check(input logic [74:0] seen, input logic [74:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Waits a bounded time for a snapshot, compares it, then takes it.
  task automatic take_snap(input logic [74:0] exp);
    int w;
    w = 0;
    while (valid !== 1'b1 && w < 50) begin
      @(negedge clk);
      w++;
    end
    check(valid, 1'b1);
    check(snap, exp);
    ready = 1'b1;
    @(negedge clk);
    ready = 1'b0;
  endtask : take_snap
  task automatic t_id();
    u_ctl.walk(8'h00, 1);
    u_ctl.dr_scan(32, '0);
    check(u_ctl.dr_seen, {ID_HI, 1'b1});
    check(oe_n, 1'b1);
    u_ctl.ir_scan(3'h1);
    check(u_ctl.ir_seen[1:0], 2'b01);
    u_ctl.dr_scan(32, '0);
    check(u_ctl.dr_seen[0], 1'b1);
    check(u_ctl.dr_seen, {ID_HI, 1'b1});
  endtask : t_id
  // Bypass gives a one-bit path that captures zero, so every bit comes
  // out one scan step late behind a leading zero.
  task automatic t_bypass();
    logic [7:0] din [2];
    din = '{8'ha5, 8'h3c};
    // only implemented codes are ever loaded
    u_ctl.ir_scan(3'h7);
    foreach (din[i]) begin
      u_ctl.dr_scan(8, {67'h0, din[i]});
      check(u_ctl.dr_seen, {din[i][6:0], 1'b0});
      check(dis, 1'b0);
    end
  endtask : t_bypass
  // Three captures with the reader stalled, then the buffer is drained.
  task automatic t_sample();
    u_ctl.ir_scan(3'h4);
    for (int i = 0; i < 3; i++) begin
      // the ring, every one of its 75 bits, is still at capture
      ring = pat[i];
      u_ctl.dr_scan((i == 2) ? 1 : 75, ~pat[i]);
      if (i < 2) check(u_ctl.dr_seen, pat[i]);
      check(dis, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      take_snap(pat[i]);
    end
    check(valid, 1'b0);
  endtask : t_sample
  // Codes 000 and 010 both disable outputs until the mode-high reset.
  task automatic t_extest();
    for (int i = 0; i < 2; i++) begin
      ring = pat[i];
      u_ctl.ir_scan(i == 0 ? 3'h0 : 3'h2);
      check(dis, 1'b1);
      u_ctl.dr_scan(75, '0);
      check(u_ctl.dr_seen, pat[i]);
      take_snap(pat[i]);
    end
    u_ctl.go_reset();
    check(dis, 1'b0);
    u_ctl.dr_scan(32, '0);
    check(u_ctl.dr_seen, {ID_HI, 1'b1});
  endtask : t_extest
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    rst_n = 1'b0;
    ready = 1'b0;
    ring = '0;
    pat[0] = {11'h5a3, 64'h0123456789abcdef};
    pat[1] = ~pat[0];
    pat[2] = {11'h001, 64'h8000000000000001};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    report_and_stop();
  end
endmodule : tb_stil_tap
